// ---- src/sac_cfg.svh ----
// constants and register layout of the converter control block
// Overview of operation
// - interrupt at every conversion end when enabled
// - enabled interrupt keeps done flag clear, reads zero
// - done flag set at end, cleared by result read
// - result read or control write drops interrupt
// - converting continues in wait, interrupt wakes processor
// - stop mode aborts conversion, resumes on exit
// - continuous bit repeats conversions, else one only
// - five-bit select, codes 0-3 pick pins
// - all-ones select powers down, reset value
// - codes 1D/1E route supply/ground references
// - one 8-bit result loaded per conversion
// - 3-bit divider: 1,2,4,8, top bit 16
// - sixteen conversion clocks, start after control write
// - continuous results overwrite unread previous ones
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
`define SAC_ADR_SC 8'h00
`define SAC_ADR_RES 8'h04
`define SAC_ADR_CLK 8'h08
`define SAC_ADR_IST 8'h0C
`define SAC_ADR_IMSK 8'h10
`define SAC_SC_DONE 7
`define SAC_SC_IEN 6
`define SAC_SC_CONT 5
`define SAC_SC_RST 8'h1F
`define SAC_CLK_RST 3'h0
`define SAC_CLK_LSB 5
`define SAC_SEL_OFF 5'h1F
`define SAC_SEL_SUPPLY 5'h1D
`define SAC_SEL_GROUND 5'h1E
`define SAC_SEL_PINS 5'h03
`define SAC_IST_DONE 0
`define SAC_IST_ABORT 1
`define SAC_CONV_TICKS 5'h10
`define SAC_SAMPLE_TICKS 4'h8
`endif

// ---- src/sac_pkg.sv ----
// types and shared decode for the converter control block
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_ARM = 2'b01,
    SAC_RUN = 2'b11
  } sac_state_t;

  // divider compare mask: codes with top bit set all divide by 16
  function automatic logic [3:0] sac_div_mask(input logic [2:0] code);
    case (code)
      3'h0: sac_div_mask = 4'h0;
      3'h1: sac_div_mask = 4'h1;
      3'h2: sac_div_mask = 4'h3;
      3'h3: sac_div_mask = 4'h7;
      default: sac_div_mask = 4'hF;
    endcase
  endfunction
endpackage

// ---- src/sac_clk_div.sv ----
// prescaler making the conversion clock tick from the bus clock
`timescale 1ns/10ps
`include "sac_cfg.svh"
module sac_clk_div
  import sac_pkg::*;
(
  input wire logic clk_i, // bus clock
  input wire logic rst_i, // sync reset
  input wire logic [2:0] div_i, // clock_divide code
  output logic tick_o // conversion clock rising edge
);
  logic [3:0] cnt_reg;
  logic [3:0] mask;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  assign mask = sac_div_mask(div_i);
  assign tick_o = ((cnt_reg & mask) == mask);
endmodule

// ---- src/sac_sar.sv ----
// successive-approximation sequencer, sample phase then MSB-first
`timescale 1ns/10ps
`include "sac_cfg.svh"
module sac_sar (
  input wire logic clk_i, // bus clock
  input wire logic rst_i, // sync reset
  input wire logic start_i, // begin on this tick
  input wire logic abort_i, // drop conversion
  input wire logic tick_i, // conversion clock edge
  input wire logic comp_i, // 1: input at or above trial
  output logic busy_o, // conversion in progress
  output logic sample_o, // sample switch closed
  output logic done_o, // one-cycle end pulse
  output logic [7:0] trial_o, // trial code to the dac
  output logic [7:0] result_o // last finished code
);
  logic [3:0] cnt_reg;
  logic [2:0] bit_idx;
  logic [7:0] kept;

  assign bit_idx = 3'(4'hF - cnt_reg);
  assign kept = comp_i ? trial_o : (trial_o & ~(8'h01 << bit_idx));
  assign sample_o = busy_o && (cnt_reg < `SAC_SAMPLE_TICKS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      cnt_reg <= 4'h0;
      trial_o <= 8'h00;
      result_o <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        // the start tick is the first of sixteen
        busy_o <= 1'b1;
        cnt_reg <= 4'h1;
        trial_o <= 8'h80;
      end else if (abort_i) begin
        busy_o <= 1'b0;
      end else if (busy_o && tick_i) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg >= `SAC_SAMPLE_TICKS) begin
          trial_o <= kept | ((8'h01 << bit_idx) >> 1);
          if (cnt_reg == 4'hF) begin
            busy_o <= 1'b0;
            result_o <= kept;
            done_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ---- src/sac_top.sv ----
// converter control with wishbone registers, interrupts, sequencing
`timescale 1ns/10ps
`include "sac_cfg.svh"
module sac_top
  import sac_pkg::*;
(
  input wire logic clk_i, // bus clock 100 MHz
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic stop_i, // processor in stop mode
  input wire logic comp_i, // comparator decision
  output logic [7:0] dac_code_o, // trial code
  output logic sample_o, // sample switch
  output logic [4:0] input_select_o, // mux select
  output logic [3:0] pin_override_o, // pin forced analog
  output logic ref_supply_o, // route analog_supply_ref
  output logic ref_ground_o, // route analog_ground_ref
  output logic power_down_o, // analog off
  output logic irq_o // interrupt, level
);
  sac_state_t state_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [4:0] input_select;
  logic conv_irq_enable;
  logic continuous_conv;
  logic conv_done_flag;
  logic pend_reg;
  logic [2:0] clock_divide;
  logic [1:0] ist_reg;
  logic [1:0] imask_reg;
  logic [7:0] result_reg;
  logic req;
  logic wr;
  logic rd;
  logic wr_sc;
  logic rd_res;
  logic [7:0] sc_val;
  logic tick;
  logic sar_start;
  logic sar_abort;
  logic sar_busy;
  logic sar_done;
  logic [7:0] sar_result;
  logic stop_abort;
  logic sel_off;

  // bus: answer one cycle after the request, act on the ack edge
  // acting only on the ack edge keeps a held request from acting twice
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && ack_reg && wb_sel_i[0];
  assign rd = req && !wb_we_i && ack_reg;
  assign wr_sc = wr && (wb_adr_i == `SAC_ADR_SC);
  assign rd_res = rd && (wb_adr_i == `SAC_ADR_RES);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  assign sc_val = {conv_done_flag && !conv_irq_enable, conv_irq_enable,
                   continuous_conv, input_select};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req && !ack_reg;
      rdat_reg <= 32'h0000_0000;
      if (req && !ack_reg && !wb_we_i) begin
        case (wb_adr_i)
          `SAC_ADR_SC: rdat_reg <= {24'h000000, sc_val};
          `SAC_ADR_RES: rdat_reg <= {24'h000000, result_reg};
          `SAC_ADR_CLK: rdat_reg <= {24'h000000, clock_divide, 5'h00};
          `SAC_ADR_IST: rdat_reg <= {30'h0, ist_reg};
          `SAC_ADR_IMSK: rdat_reg <= {30'h0, imask_reg};
          default: rdat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control registers; a written done bit is ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_select <= 5'(`SAC_SC_RST & 8'h1F);
      conv_irq_enable <= 1'b0;
      continuous_conv <= 1'b0;
      clock_divide <= `SAC_CLK_RST;
      imask_reg <= 2'h0;
    end else if (wr) begin
      if (wb_adr_i == `SAC_ADR_SC) begin
        input_select <= wb_dat_i[4:0];
        conv_irq_enable <= wb_dat_i[`SAC_SC_IEN];
        continuous_conv <= wb_dat_i[`SAC_SC_CONT];
      end
      if (wb_adr_i == `SAC_ADR_CLK) begin
        clock_divide <= wb_dat_i[`SAC_CLK_LSB +: 3];
      end
      if (wb_adr_i == `SAC_ADR_IMSK) begin
        imask_reg <= wb_dat_i[1:0];
      end
    end
  end

  sac_clk_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(clock_divide),
    .tick_o(tick)
  );

  sac_sar u_sar (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(sar_start),
    .abort_i(sar_abort),
    .tick_i(tick),
    .comp_i(comp_i),
    .busy_o(sar_busy),
    .sample_o(sample_o),
    .done_o(sar_done),
    .trial_o(dac_code_o),
    .result_o(sar_result)
  );

  assign sel_off = (input_select == `SAC_SEL_OFF);
  // first conversion-clock edge after arming
  // a write on the same edge wins and re-arms or idles, so an off code never starts
  assign sar_start = (state_reg == SAC_ARM) && tick && !stop_i && !sel_off &&
                     !wr_sc;
  // only a live conversion is aborted; the end cycle is no longer busy
  assign stop_abort = sar_busy && stop_i;
  // stop or a control write aborts
  assign sar_abort = stop_abort || wr_sc;

  // sequencing state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SAC_IDLE;
    end else begin
      case (state_reg)
        SAC_IDLE: begin
          if (wr_sc && (wb_dat_i[4:0] != `SAC_SEL_OFF)) begin
            state_reg <= SAC_ARM;
          end
        end
        SAC_ARM: begin
          if (wr_sc && (wb_dat_i[4:0] == `SAC_SEL_OFF)) begin
            state_reg <= SAC_IDLE;
          end else if (sar_start) begin
            state_reg <= SAC_RUN;
          end
        end
        SAC_RUN: begin
          if (wr_sc) begin
            state_reg <= (wb_dat_i[4:0] == `SAC_SEL_OFF) ? SAC_IDLE : SAC_ARM;
          end else if (sar_done) begin
            // repeat or finish; a finished single run ignores stop
            state_reg <= continuous_conv ? SAC_ARM : SAC_IDLE;
          end else if (stop_i) begin
            state_reg <= SAC_ARM;
          end
        end
        default: state_reg <= SAC_IDLE;
      endcase
    end
  end

  // every finished code overwrites the result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= 8'h00;
    end else if (sar_done) begin
      result_reg <= sar_result;
    end
  end

  // flag: set wins over the result-read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_done_flag <= 1'b0;
    end else if (sar_done && !conv_irq_enable) begin
      conv_done_flag <= 1'b1;
    end else if (rd_res) begin
      conv_done_flag <= 1'b0;
    end
  end

  // request raised at end, dropped by read or write; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
    end else if (sar_done && conv_irq_enable) begin
      pend_reg <= 1'b1;
    end else if (rd_res || wr_sc) begin
      pend_reg <= 1'b0;
    end
  end

  // sticky events, write one to clear, new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_reg <= 2'h0;
    end else begin
      ist_reg[`SAC_IST_DONE] <= sar_done || (ist_reg[`SAC_IST_DONE] &&
        !(wr && wb_adr_i == `SAC_ADR_IST && wb_dat_i[`SAC_IST_DONE]));
      ist_reg[`SAC_IST_ABORT] <= stop_abort || (ist_reg[`SAC_IST_ABORT] &&
        !(wr && wb_adr_i == `SAC_ADR_IST && wb_dat_i[`SAC_IST_ABORT]));
    end
  end

  // pending request reaches the processor in wait too
  assign irq_o = pend_reg || |(ist_reg & imask_reg);

  assign input_select_o = input_select;
  assign power_down_o = sel_off;
  assign ref_supply_o = (input_select == `SAC_SEL_SUPPLY);
  assign ref_ground_o = (input_select == `SAC_SEL_GROUND);
  always_comb begin
    pin_override_o = 4'h0;
    if (input_select <= `SAC_SEL_PINS) begin
      pin_override_o[input_select[1:0]] = 1'b1;
    end
  end

  sequence s_end_ien;
    sar_done && conv_irq_enable;
  endsequence
  sequence s_end_poll;
    sar_done && !conv_irq_enable;
  endsequence

  property p_irq_on_end;
    @(posedge clk_i) disable iff (rst_i) s_end_ien |=> pend_reg && irq_o;
  endproperty
  a_irq_on_end: assert property (p_irq_on_end)
    else $error("no interrupt after conversion end");

  property p_flag_hidden;
    @(posedge clk_i) disable iff (rst_i)
      // an end in interrupt mode must leave the flag clear
      s_end_ien && !conv_done_flag |=>
        !conv_done_flag && !sc_val[`SAC_SC_DONE];
  endproperty
  a_flag_hidden: assert property (p_flag_hidden)
    else $error("done flag visible with interrupt enabled");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i) s_end_poll |=> conv_done_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("done flag not set at end");

  property p_irq_drop;
    @(posedge clk_i) disable iff (rst_i)
      (rd_res || wr_sc) && !sar_done |=> !pend_reg;
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("interrupt not dropped");

  property p_stop_abort;
    @(posedge clk_i) disable iff (rst_i)
      stop_i && sar_busy |=> !sar_busy && state_reg != SAC_RUN;
  endproperty
  a_stop_abort: assert property (p_stop_abort)
    else $error("conversion survives stop");

  property p_single;
    @(posedge clk_i) disable iff (rst_i)
      sar_done && !continuous_conv && !wr_sc |=> state_reg == SAC_IDLE;
  endproperty
  a_single: assert property (p_single)
    else $error("single mode did not stop");

  property p_power_off;
    @(posedge clk_i) disable iff (rst_i)
      sel_off && $past(sel_off) |-> !sar_busy && power_down_o;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("converter busy while powered down");

  property p_result_load;
    @(posedge clk_i) disable iff (rst_i)
      sar_done |=> result_reg == $past(sar_result);
  endproperty
  a_result_load: assert property (p_result_load)
    else $error("result not loaded");

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
      sar_start |=> sar_busy && sample_o && dac_code_o == 8'h80;
  endproperty
  a_start: assert property (p_start)
    else $error("conversion did not start on tick");
endmodule

// ---- testbench/sac_comp_model.sv ----
// comparator and input multiplexer standing in for the analog side
`timescale 1ns/10ps
module sac_comp_model (
  input wire logic [7:0] dac_code_i, // trial code
  input wire logic [3:0] pin_override_i, // routed pin
  input wire logic ref_supply_i, // supply node routed
  input wire logic ref_ground_i, // ground node routed
  input wire logic power_down_i, // analog off
  input wire logic [31:0] pin_lvl_i, // four pin levels
  output logic comp_o // 1: input at or above trial
);
  logic [7:0] vin;
  logic hit;
  always_comb begin
    vin = 8'h00;
    hit = 1'b1;
    case (pin_override_i)
      4'h1: vin = pin_lvl_i[7:0];
      4'h2: vin = pin_lvl_i[15:8];
      4'h4: vin = pin_lvl_i[23:16];
      4'h8: vin = pin_lvl_i[31:24];
      default: hit = 1'b0;
    endcase
    if (ref_supply_i) begin
      vin = 8'hFF;
      hit = 1'b1;
    end
    if (ref_ground_i) begin
      vin = 8'h00;
      hit = 1'b1;
    end
  end
  // unrouted or off gives noise, not a held level
  assign comp_o = (hit && !power_down_i) ? (vin >= dac_code_i) :
                  ~dac_code_i[0];
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the converter control block
`timescale 1ns/10ps
module testbench;
  import sac_pkg::*;
  typedef struct {logic [4:0] sel; logic [2:0] div; logic [7:0] ex;} sac_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, stop = 1'b0, comp;
  logic [7:0] adr = 8'h00, dac;
  logic [4:0] sel5;
  logic [31:0] dat = 32'h0, dat_o, lvl = 32'h0, q, t;
  logic ack, smp, supply, ground, pdn, irq;
  logic [3:0] pin;
  int err_total = 0, total_checks = 0, cycles = 0, n;
  sac_row_t r;
  sac_row_t rows [8] = '{'{5'h00, 3'h0, 8'h5A}, '{5'h01, 3'h1, 8'hA5},
    '{5'h02, 3'h2, 8'h01}, '{5'h03, 3'h3, 8'hFE}, '{5'h00, 3'h4, 8'h80},
    '{5'h03, 3'h7, 8'h7F}, '{5'h1D, 3'h0, 8'hFF}, '{5'h1E, 3'h0, 8'h00}};

  always #5 clk_i = ~clk_i;

  sac_top i_sac_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .stop_i(stop),
    .comp_i(comp), .dac_code_o(dac), .sample_o(smp),
    .input_select_o(sel5), .pin_override_o(pin), .ref_supply_o(supply),
    .ref_ground_o(ground), .power_down_o(pdn), .irq_o(irq));

  sac_comp_model i_sac_comp_model (.dac_code_i(dac), .pin_override_i(pin),
    .ref_supply_i(supply), .ref_ground_i(ground), .power_down_i(pdn),
    .pin_lvl_i(lvl), .comp_o(comp));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_flag();
    q = 32'h0;
    for (int k = 0; k < 200 && q[7] !== 1'b1; k++) wb(1'b0, 8'h00, 32'h0);
  endtask

  task automatic wait_irq();
    for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk_i);
  endtask

  task automatic idle_check(input int c);
    for (int k = 0; k < c; k++) begin
      @(posedge clk_i);
      if (smp !== 1'b0) chk(smp, 1'b0);
    end
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end

  // a control read after a result read shows the done bit at zero
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({pdn, sel5, irq}, 7'h7E);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h1F);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    // first result after leaving power-down is thrown away
    wb(1'b1, 8'h00, 32'h0);
    wait_flag();
    wb(1'b0, 8'h04, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      t = {4{~r.ex}};
      if (r.sel < 5'h04) t[r.sel[1:0]*8 +: 8] = r.ex;
      lvl <= t;
      wb(1'b1, 8'h08, {24'h0, r.div, 5'h00});
      wb(1'b1, 8'h00, {27'h0, r.sel});
      @(posedge clk_i);
      chk({sel5, pdn}, {r.sel, 1'b0});
      chk(pin, (r.sel < 5'h04) ? 32'h1 << r.sel : 32'h0);
      chk({supply, ground}, {r.sel == 5'h1D, r.sel == 5'h1E});
      for (n = 0; n < 40 && smp !== 1'b1; n++) @(posedge clk_i);
      for (n = 0; n < 200 && smp === 1'b1; n++) @(posedge clk_i);
      // ticks per conversion clock follow the divide code
      chk(n, 7 << (r.div[2] ? 4 : r.div[1:0]));
      wait_flag();
      chk(q, {27'h0, r.sel} | 32'h80);
      wb(1'b0, 8'h04, 32'h0);
      chk(q, r.ex);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, {27'h0, r.sel});
    end
    idle_check(60);
    lvl <= 32'h00000096;
    wb(1'b1, 8'h00, 32'h40);
    wait_irq();
    chk(irq, 1'b1);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h40);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h96);
    @(posedge clk_i);
    chk(irq, 1'b0);
    wb(1'b1, 8'h00, 32'h40);
    wait_irq();
    chk(irq, 1'b1);
    wb(1'b1, 8'h00, 32'h5F);
    @(posedge clk_i);
    chk({irq, pdn}, 2'b01);
    wb(1'b1, 8'h0C, 32'h3);
    wb(1'b1, 8'h10, 32'h1);
    wb(1'b1, 8'h00, 32'h00);
    wait_irq();
    wb(1'b0, 8'h04, 32'h0); // first result after power-down discarded
    @(posedge clk_i);
    chk(irq, 1'b1);
    wb(1'b1, 8'h0C, 32'h1);
    @(posedge clk_i);
    chk(irq, 1'b0);
    wb(1'b1, 8'h10, 32'h0);
    // continuous: unread results are overwritten
    lvl <= 32'h11;
    wb(1'b1, 8'h00, 32'h20);
    wait_flag();
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h11);
    lvl <= 32'h44;
    repeat (60) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h44);
    // stop mid-sample with slow clock, then resume
    lvl <= 32'h3C;
    wb(1'b1, 8'h08, 32'h80);
    // write lands mid-conversion; its result is thrown away
    wb(1'b1, 8'h00, 32'h00);
    wb(1'b0, 8'h04, 32'h0);
    // events cleared only once the continuous run has stopped
    wb(1'b1, 8'h0C, 32'h3);
    for (n = 0; n < 40 && smp !== 1'b1; n++) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    stop <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk(smp, 1'b0);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h2);
    stop <= 1'b0;
    // only a full conversion after stop is trusted
    wait_flag();
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h3C);
    wb(1'b1, 8'h00, 32'h1F);
    @(posedge clk_i);
    chk(pdn, 1'b1);
    idle_check(60);
    wb(1'b1, 8'h40, 32'h55);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    end_of_test();
  end
endmodule
